// File: core/bcr_pkg.sv
package bcr_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam int AW = 16;
   localparam logic [AW-1:0] A_SPCFG = 16'h0000;
   localparam logic [AW-1:0] A_ID_LO = 16'h0002;
   localparam logic [AW-1:0] A_ID_HI = 16'h0003;
   localparam logic [AW-1:0] A_RBSEL = 16'h0004;
   localparam logic [AW-1:0] A_UPD = 16'h0005;
   localparam logic [AW-1:0] A_PWR = 16'h0010;
   localparam logic [AW-1:0] A_PRST = 16'h0012;
   localparam logic [AW-1:0] A_HRST = 16'h0013;
   localparam logic [AW-1:0] A_NDIV = 16'h0020;
   localparam logic [AW-1:0] A_PLL = 16'h0022;

   // buffered bytes: out-of-range limit, detector gains, phase offset, spur cancellers
   localparam int NM = 18;
   localparam logic [NM-1:0][AW-1:0] M_ADDR = {
      16'h0509, 16'h0508, 16'h0507, 16'h0506, 16'h0505, 16'h0504, 16'h0503, 16'h0502, 16'h0501,
      16'h0500, 16'h040a, 16'h0409, 16'h0403, 16'h0402, 16'h0335, 16'h0334, 16'h0333, 16'h0332};
   localparam logic [NM-1:0][7:0] M_RST = '0;
   // direct bytes: calibration divider, fine gain, dac current, bias level
   localparam int NP = 6;
   localparam logic [NP-1:0][AW-1:0] P_ADDR = {16'h040f, 16'h040c, 16'h040b, 16'h0404, 16'h0401, 16'h0400};
   localparam logic [NP-1:0][7:0] P_RST = {8'h00, 8'h01, 8'h00, 8'hc8, 8'h00, 8'h00};

   // ----------------------------------------
   // field positions and defaults
   // ----------------------------------------
   localparam int SC_SDO = 0;
   localparam int SC_LSB = 1;
   localparam int SC_SOFT = 2;
   localparam int SC_LONG = 3;
   localparam int RB_BIT = 0;
   localparam int UPD_BIT = 0;
   localparam int PW_DIG = 0;
   localparam int PW_FULL = 1;
   localparam int PW_REFB = 2;
   localparam int PW_REFA = 3;
   localparam int PW_SPLL = 4;
   localparam int PW_DBL = 5;
   localparam int PW_CMOS = 6;
   localparam int PW_HSTL = 7;
   localparam int PLL_VCO = 2;
   localparam int PLL_X2 = 3;
   localparam int PLL_AUTO = 7;
   localparam logic [7:0] PWR_RST = 8'h00;
   localparam logic [7:0] HRST_RST = 8'h00;
   localparam logic [4:0] NDIV_RST = 5'h00;
   localparam logic [7:0] PLL_RST = 8'h00;
   localparam logic [5:0] N_OFFSET = 6'h02;
   localparam logic [1:0] CP_250 = 2'h0;
   localparam logic [1:0] CP_375 = 2'h1;
   localparam logic [1:0] CP_OFF = 2'h2;
   localparam logic [8:0] UA_250 = 9'h0fa;
   localparam logic [8:0] UA_375 = 9'h177;
   localparam logic [8:0] UA_125 = 9'h07d;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic we;
      logic re;
      logic [AW-1:0] addr;
      logic [7:0] wdata;
   } bcr_req_t;

   typedef struct packed {
      logic sdo_en;
      logic lsb_first;
      logic dig_pd;
      logic full_pd;
      logic refb_pd;
      logic refa_pd;
      logic sysclk_pll_pd;
      logic doubler_pwr;
      logic cmos_on;
      logic hstl_pd;
      logic [7:0] pulse_rst;
      logic [7:0] held_rst;
      logic [6:0] fb_ratio;
      logic [8:0] cp_ua;
      logic vco_high;
      logic ref_x2;
      logic [NM-1:0][7:0] mirr;
      logic [NP-1:0][7:0] plain;
   } bcr_ctl_t;

   typedef struct packed {
      logic [2:0] cfg;
      logic lsb_act;
      logic rbsel;
      logic [7:0] pwr;
      logic [7:0] hrst;
      logic [4:0] ndiv;
      logic [7:0] pll;
      logic [NM-1:0][7:0] mbuf;
      logic [NM-1:0][7:0] mact;
      logic [NP-1:0][7:0] plain;
      logic [3:0] strap;
      logic [7:0] rdata;
      logic rvalid;
      bcr_ctl_t ctl;
   } bcr_state_t;

endpackage

// File: core/bcr_bank.sv
`timescale 1ns/1ps

// Function
// - buffered writes wait for an update strobe
// - config upper nibble mirrors lower nibble
// - bit 0 enables data output, four-wire
// - bit order bit, effective after update
// - soft reset restores all but config
// - startup pins kept from last hard reset
// - long-instruction bit reads one, read-only
// - identity bytes read-only, writes ignored
// - readback select picks pending or active
// - update bit acts as update pin
// - digital power-down stops digital clock
// - full power-down like the pin
// - bits 2,3 power down references B,A
// - bits 4-7 multiplier, doubler, cmos, differential
// - pulsed reset bits self-clear, fixed order
// - interrupt reset clears interrupt state
// - history reset clears tuning word history
// - held resets: dividers and prescalers
// - bit 7 suppresses fundamental, spurs stay
// - feedback ratio twice field plus two
// - charge pump code decode
// - range bit, set by auto-range
module bcr_bank #(
   parameter logic [15:0] ID_VALUE = 16'h5a3c // arbitrary identity value
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   // serial port engine side
   input wire bcr_pkg::bcr_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   // device pins
   input wire logic upd_pin,
   input wire logic pd_pin,
   input wire logic [3:0] startup_config_pins,
   input wire logic vco_auto_high,
   output logic [3:0] startup_latched,
   // controls to the datapath
   output bcr_pkg::bcr_ctl_t ctl
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic bcr_pkg::bcr_ctl_t derive(bcr_pkg::bcr_state_t x, logic pd);
      bcr_pkg::bcr_ctl_t c;
      c = x.ctl;
      c.sdo_en = x.cfg[bcr_pkg::SC_SDO];
      c.lsb_first = x.lsb_act;
      // the serial port stays alive through both power-down modes
      c.dig_pd = x.pwr[bcr_pkg::PW_DIG] | x.pwr[bcr_pkg::PW_FULL] | pd;
      c.full_pd = x.pwr[bcr_pkg::PW_FULL] | pd;
      c.refb_pd = x.pwr[bcr_pkg::PW_REFB] | c.full_pd;
      c.refa_pd = x.pwr[bcr_pkg::PW_REFA] | c.full_pd;
      c.sysclk_pll_pd = x.pwr[bcr_pkg::PW_SPLL] | c.full_pd;
      // the doubler also needs its own enable elsewhere before it runs
      c.doubler_pwr = x.pwr[bcr_pkg::PW_DBL] & ~c.full_pd;
      c.cmos_on = x.pwr[bcr_pkg::PW_CMOS] & ~c.full_pd;
      c.hstl_pd = x.pwr[bcr_pkg::PW_HSTL] | c.full_pd;
      c.held_rst = x.hrst;
      c.fb_ratio = {6'(x.ndiv) + bcr_pkg::N_OFFSET, 1'b0};
      case (x.pll[1:0])
         bcr_pkg::CP_250: c.cp_ua = bcr_pkg::UA_250;
         bcr_pkg::CP_375: c.cp_ua = bcr_pkg::UA_375;
         bcr_pkg::CP_OFF: c.cp_ua = '0;
         default: c.cp_ua = bcr_pkg::UA_125;
      endcase
      c.vco_high = x.pll[bcr_pkg::PLL_VCO];
      c.ref_x2 = x.pll[bcr_pkg::PLL_X2];
      c.mirr = x.mact;
      c.plain = x.plain;
      return c;
   endfunction

   // every register except the config byte and the latched straps
   function automatic bcr_pkg::bcr_state_t defaults(bcr_pkg::bcr_state_t cur);
      bcr_pkg::bcr_state_t d;
      d = cur;
      d.rbsel = 1'b0;
      d.pwr = bcr_pkg::PWR_RST;
      d.hrst = bcr_pkg::HRST_RST;
      d.ndiv = bcr_pkg::NDIV_RST;
      d.pll = bcr_pkg::PLL_RST;
      d.mbuf = bcr_pkg::M_RST;
      d.mact = bcr_pkg::M_RST;
      d.plain = bcr_pkg::P_RST;
      return d;
   endfunction

   function automatic logic [7:0] cfg_byte(logic [2:0] c, logic lsb);
      logic [3:0] lo;
      lo = {1'b1, c[bcr_pkg::SC_SOFT], lsb, c[bcr_pkg::SC_SDO]};
      return {lo[0], lo[1], lo[2], lo[3], lo};
   endfunction

   // ----------------------------------------
   // state
   // ----------------------------------------
   bcr_pkg::bcr_state_t s_q;
   bcr_pkg::bcr_state_t s_d;
   bcr_pkg::bcr_state_t s_rst;
   logic upd;
   logic soft_nx;
   logic [bcr_pkg::NM-1:0] m_hit;
   logic [bcr_pkg::NP-1:0] p_hit;

   genvar gi;
   generate
      for (gi = 0; gi < bcr_pkg::NM; gi++) begin : g_m
         assign m_hit[gi] = req.addr == bcr_pkg::M_ADDR[gi];
      end
      for (gi = 0; gi < bcr_pkg::NP; gi++) begin : g_p
         assign p_hit[gi] = req.addr == bcr_pkg::P_ADDR[gi];
      end
   endgenerate

   always_comb begin
      s_rst = '0;
      s_rst = defaults(s_rst);
      s_rst.ctl = derive(s_rst, 1'b0);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ctl.pulse_rst = '0;
      s_d.rvalid = 1'b0;
      upd = upd_pin | (req.we && req.addr == bcr_pkg::A_UPD && req.wdata[bcr_pkg::UPD_BIT]);
      // the update moves the old buffer; a same-cycle write lands in the buffer for next time
      if (upd) begin
         s_d.mact = s_q.mbuf;
         s_d.lsb_act = s_q.cfg[bcr_pkg::SC_LSB];
      end
      if (req.we) begin
         case (req.addr)
            bcr_pkg::A_SPCFG: s_d.cfg = req.wdata[2:0];
            bcr_pkg::A_RBSEL: s_d.rbsel = req.wdata[bcr_pkg::RB_BIT];
            bcr_pkg::A_PWR: s_d.pwr = req.wdata;
            // bit 5 clears interrupt state, bit 7 the tuning word history
            bcr_pkg::A_PRST: s_d.ctl.pulse_rst = req.wdata;
            bcr_pkg::A_HRST: s_d.hrst = req.wdata;
            bcr_pkg::A_NDIV: s_d.ndiv = req.wdata[4:0];
            bcr_pkg::A_PLL: s_d.pll = req.wdata;
            default: s_d.rbsel = s_d.rbsel; // identity and unmapped: ignored
         endcase
         for (int i = 0; i < bcr_pkg::NM; i++) begin
            if (m_hit[i]) begin
               s_d.mbuf[i] = req.wdata;
            end
         end
         for (int i = 0; i < bcr_pkg::NP; i++) begin
            if (p_hit[i]) begin
               s_d.plain[i] = req.wdata;
            end
         end
      end
      if (s_d.pll[bcr_pkg::PLL_AUTO]) begin
         s_d.pll[bcr_pkg::PLL_VCO] = vco_auto_high;
      end
      // held soft reset keeps everything at defaults until the host clears it
      soft_nx = s_d.cfg[bcr_pkg::SC_SOFT];
      if (soft_nx) begin
         s_d = defaults(s_d);
      end
      if (req.re) begin
         s_d.rvalid = 1'b1;
         case (req.addr)
            bcr_pkg::A_SPCFG: s_d.rdata = cfg_byte(s_q.cfg, s_q.rbsel ? s_q.cfg[bcr_pkg::SC_LSB] : s_q.lsb_act);
            bcr_pkg::A_ID_LO: s_d.rdata = ID_VALUE[7:0];
            bcr_pkg::A_ID_HI: s_d.rdata = ID_VALUE[15:8];
            bcr_pkg::A_RBSEL: s_d.rdata = {7'h00, s_q.rbsel};
            bcr_pkg::A_PWR: s_d.rdata = s_q.pwr;
            bcr_pkg::A_HRST: s_d.rdata = s_q.hrst;
            bcr_pkg::A_NDIV: s_d.rdata = {3'h0, s_q.ndiv};
            bcr_pkg::A_PLL: s_d.rdata = s_q.pll;
            default: s_d.rdata = 8'h00; // update and pulsed bytes read zero
         endcase
         for (int i = 0; i < bcr_pkg::NM; i++) begin
            if (m_hit[i]) begin
               s_d.rdata = s_q.rbsel ? s_q.mbuf[i] : s_q.mact[i];
            end
         end
         for (int i = 0; i < bcr_pkg::NP; i++) begin
            if (p_hit[i]) begin
               s_d.rdata = s_q.plain[i];
            end
         end
      end
      s_d.ctl = derive(s_d, pd_pin);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s_q <= s_rst;
         s_q.strap <= startup_config_pins;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign rvalid = s_q.rvalid;
   assign startup_latched = s_q.strap;
   assign ctl = s_q.ctl;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_cfg_mirror: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_SPCFG |=> rdata[7:4] == {rdata[0], rdata[1], rdata[2], rdata[3]})
      else $error("config upper nibble not mirrored");

   a_long_ro: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_SPCFG |=> rdata[bcr_pkg::SC_LONG] && rvalid)
      else $error("long instruction bit not one");

   a_sdo_follow: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_SPCFG |=> ctl.sdo_en == $past(req.wdata[bcr_pkg::SC_SDO]))
      else $error("data output enable does not follow bit 0");

   a_order_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !upd |=> $stable(ctl.lsb_first))
      else $error("bit order changed without update");

   a_buf_update: assert property (@(posedge clk) disable iff (sys_rst)
      ce && upd && !soft_nx |=> ctl.mirr == $past(s_q.mbuf))
      else $error("update did not move buffer to active");

   a_buf_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !upd && !soft_nx |=> $stable(ctl.mirr))
      else $error("active buffered value moved without update");

   a_id_const: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_ID_HI |=> rdata == ID_VALUE[15:8])
      else $error("identity byte wrong");

   a_rb_pending: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && m_hit[0] && s_q.rbsel |=> rdata == $past(s_q.mbuf[0]))
      else $error("readback select ignored");

   a_pulse_once: assert property (@(posedge clk) disable iff (sys_rst)
      ce && ctl.pulse_rst != 8'h00 && !(req.we && req.addr == bcr_pkg::A_PRST) |=> ctl.pulse_rst == 8'h00)
      else $error("reset pulse longer than one cycle");

   a_soft_dflt: assert property (@(posedge clk) disable iff (sys_rst)
      ce && soft_nx |=> s_q.pwr == bcr_pkg::PWR_RST && s_q.hrst == bcr_pkg::HRST_RST && s_q.strap == $past(s_q.strap))
      else $error("soft reset left a register off default");

   a_cp_off: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_PLL && req.wdata[1:0] == 2'h2 && !soft_nx |=> ctl.cp_ua == 9'h000)
      else $error("charge pump not off for code 10");

   a_ratio_zero: assert property (@(posedge clk) disable iff (sys_rst)
      s_q.ndiv == 5'h00 |-> ctl.fb_ratio == 7'h04)
      else $error("feedback ratio not four for zero field");

   // ----------------------------------------
   // power, reset, pll, config and readback checks
   // ----------------------------------------
   a_dig_pd: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_PWR && !soft_nx && !pd_pin |=>
      ctl.dig_pd == ($past(req.wdata[bcr_pkg::PW_DIG]) || $past(req.wdata[bcr_pkg::PW_FULL])))
      else $error("digital power-down does not follow its bits");

   a_full_pin: assert property (@(posedge clk) disable iff (sys_rst)
      ce && pd_pin |=> ctl.full_pd && ctl.dig_pd && ctl.refa_pd && ctl.refb_pd && ctl.sysclk_pll_pd &&
      ctl.hstl_pd && !ctl.cmos_on && !ctl.doubler_pwr)
      else $error("power-down pin left a block powered");

   a_ref_pd: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_PWR && !soft_nx && !pd_pin && !req.wdata[bcr_pkg::PW_FULL] |=>
      ctl.refb_pd == $past(req.wdata[bcr_pkg::PW_REFB]) && ctl.refa_pd == $past(req.wdata[bcr_pkg::PW_REFA]))
      else $error("reference power-down does not follow its bits");

   a_drv_pd: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_PWR && !soft_nx && !pd_pin && !req.wdata[bcr_pkg::PW_FULL] |=>
      ctl.sysclk_pll_pd == $past(req.wdata[bcr_pkg::PW_SPLL]) &&
      ctl.doubler_pwr == $past(req.wdata[bcr_pkg::PW_DBL]) &&
      ctl.cmos_on == $past(req.wdata[bcr_pkg::PW_CMOS]) &&
      ctl.hstl_pd == $past(req.wdata[bcr_pkg::PW_HSTL]))
      else $error("multiplier or driver power does not follow its bits");

   a_pulse_load: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_PRST |=> ctl.pulse_rst == $past(req.wdata))
      else $error("reset pulses do not match the written bits");

   a_pulse_read: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_PRST |=> rdata == 8'h00)
      else $error("pulsed reset byte does not read zero");

   a_upd_read: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_UPD |=> rdata == 8'h00)
      else $error("update byte does not read zero");

   a_upd_write: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_UPD && req.wdata[bcr_pkg::UPD_BIT] && !soft_nx |=>
      ctl.mirr == $past(s_q.mbuf))
      else $error("update bit did not move buffer to active");

   a_held_follow: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_HRST && !soft_nx |=> ctl.held_rst == $past(req.wdata))
      else $error("held resets do not match the written bits");

   a_held_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ce && !(req.we && req.addr == bcr_pkg::A_HRST) && !soft_nx |=> $stable(ctl.held_rst))
      else $error("held reset byte changed by itself");

   a_strap_hold: assert property (@(posedge clk) disable iff (sys_rst)
      ce |=> $stable(startup_latched))
      else $error("latched startup pins changed without hard reset");

   a_auto_range: assert property (@(posedge clk) disable iff (sys_rst)
      ce && s_q.pll[bcr_pkg::PLL_AUTO] && !(req.we && req.addr == bcr_pkg::A_PLL) && !soft_nx |=>
      s_q.pll[bcr_pkg::PLL_VCO] == $past(vco_auto_high))
      else $error("auto range did not set the range bit");

   a_ratio_write: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_NDIV && !soft_nx |=>
      ctl.fb_ratio == 7'(2 * ($past(req.wdata[4:0]) + bcr_pkg::N_OFFSET)))
      else $error("feedback ratio not twice field plus two");

   a_soft_buf: assert property (@(posedge clk) disable iff (sys_rst)
      ce && soft_nx |=> ctl.mirr == bcr_pkg::M_RST && ctl.plain == bcr_pkg::P_RST)
      else $error("soft reset left a calibration byte off default");

   a_cfg_kept: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.we && req.addr == bcr_pkg::A_SPCFG |=> s_q.cfg == $past(req.wdata[2:0]))
      else $error("config byte not kept as written");

   a_order_update: assert property (@(posedge clk) disable iff (sys_rst)
      ce && upd |=> ctl.lsb_first == $past(s_q.cfg[bcr_pkg::SC_LSB]))
      else $error("update did not apply the bit order");

   a_rb_active: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && m_hit[0] && !s_q.rbsel |=> rdata == $past(s_q.mact[0]))
      else $error("readback did not return the active value");

   a_id_lo: assert property (@(posedge clk) disable iff (sys_rst)
      ce && req.re && req.addr == bcr_pkg::A_ID_LO |=> rdata == ID_VALUE[7:0])
      else $error("low identity byte wrong");

endmodule

// File: test/bcr_host.sv
`timescale 1ns/1ps

// ----------------------------------------
// host controller side of the register port
// ----------------------------------------
module bcr_host (
   // clock
   input wire logic clk,
   // register port
   output bcr_pkg::bcr_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   // update strobe pin
   output logic upd
);
   initial begin
      req = '0;
      upd = 1'b0;
   end

   // released address and data flip so a stale value never passes for a live one
   task automatic idle();
      req.we <= 1'b0;
      req.re <= 1'b0;
      req.addr <= ~req.addr;
      req.wdata <= ~req.wdata;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      req.we <= 1'b1;
      req.addr <= a;
      req.wdata <= d;
      @(posedge clk);
      idle();
      #1;
   endtask

   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge clk);
      req.re <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      idle();
      #1;
      d = rdata;
      v = rvalid;
   endtask

   // one strobe after a group of buffered writes moves them together
   task automatic strobe();
      @(posedge clk);
      upd <= 1'b1;
      @(posedge clk);
      upd <= 1'b0;
      #1;
   endtask
endmodule

// File: test/buffered_control_register_bank_tb_top.sv
`timescale 1ns/1ps

// ----------------------------------------
// bench for the control register bank
// ----------------------------------------
module buffered_control_register_bank_tb_top;
   localparam logic [15:0] ID_EXP = 16'h5a3c; // arbitrary identity value
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic ce = 1'b1;
   logic pd_pin = 1'b0;
   logic vco_auto_high = 1'b0;
   logic [3:0] straps = 4'h9;
   bcr_pkg::bcr_req_t req;
   bcr_pkg::bcr_ctl_t ctl;
   logic [7:0] rdata;
   logic rvalid;
   logic upd_pin;
   logic [3:0] latched;
   logic [7:0] d;
   logic v;
   int bad_count = 0;
   int total_checks = 0;
   int cycles = 0;

   always #2.5 clk = ~clk;

   bcr_bank #(.ID_VALUE(ID_EXP)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .req(req), .rdata(rdata), .rvalid(rvalid),
      .upd_pin(upd_pin), .pd_pin(pd_pin), .startup_config_pins(straps), .vco_auto_high(vco_auto_high),
      .startup_latched(latched), .ctl(ctl));
   bcr_host host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid), .upd(upd_pin));

   task automatic finish_test();
      if (bad_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // read answers must carry rvalid as well as the data
   task automatic rchk(input logic [15:0] a, input logic [7:0] e);
      host.rd(a, d, v);
      chk({v, 7'h00, d}, {1'b1, 7'h00, e});
   endtask

   task automatic t_reset();
      rchk(16'h0000, 8'h18);
      rchk(16'h0002, ID_EXP[7:0]);
      host.wr(16'h0003, 8'h00);
      rchk(16'h0003, ID_EXP[15:8]);
      // the read pulse drops after one cycle while the data stands
      @(posedge clk);
      #1;
      chk({7'h00, rvalid, rdata}, {7'h00, 1'b0, ID_EXP[15:8]});
      rchk(16'h0404, 8'hc8);
      chk(16'(ctl.plain[2]), 16'h00c8);
      chk(16'(ctl.fb_ratio), 16'h0004);
      chk(16'(ctl.cp_ua), 16'h00fa);
   endtask

   task automatic t_cfg();
      host.wr(16'h0000, 8'hc3);
      chk(16'(ctl.sdo_en), 16'h0001);
      chk(16'(ctl.lsb_first), 16'h0000);
      rchk(16'h0000, 8'h99);
      host.strobe();
      chk(16'(ctl.lsb_first), 16'h0001);
      rchk(16'h0000, 8'hdb);
      host.wr(16'h0000, 8'h18);
      chk(16'(ctl.sdo_en), 16'h0000);
      host.strobe();
   endtask

   task automatic t_buf();
      host.wr(16'h0332, 8'haa);
      chk(16'(ctl.mirr[0]), 16'h0000);
      rchk(16'h0332, 8'h00);
      host.wr(16'h0004, 8'h01);
      rchk(16'h0332, 8'haa);
      host.wr(16'h0005, 8'h01);
      chk(16'(ctl.mirr[0]), 16'h00aa);
      rchk(16'h0005, 8'h00);
      host.wr(16'h0509, 8'h55);
      host.strobe();
      chk(16'(ctl.mirr[17]), 16'h0055);
      host.wr(16'h0004, 8'h00);
   endtask

   task automatic t_pwr();
      // full power-down drags every other block down with it
      for (int i = 0; i < 8; i++) begin
         host.wr(16'h0010, 8'h01 << i);
         chk(16'({ctl.hstl_pd, ctl.cmos_on, ctl.doubler_pwr, ctl.sysclk_pll_pd, ctl.refa_pd, ctl.refb_pd,
            ctl.full_pd, ctl.dig_pd}), (i == 1) ? 16'h009f : 16'h0001 << i);
      end
      host.wr(16'h0010, 8'h00);
      @(posedge clk);
      pd_pin <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(16'(ctl.full_pd), 16'h0001);
      @(posedge clk);
      pd_pin <= 1'b0;
   endtask

   task automatic t_rst();
      host.wr(16'h0012, 8'hbf);
      chk(16'(ctl.pulse_rst), 16'h00bf);
      @(posedge clk);
      #1;
      chk(16'(ctl.pulse_rst), 16'h0000);
      rchk(16'h0012, 8'h00);
      host.wr(16'h0013, 8'h8f);
      repeat (3) @(posedge clk);
      #1;
      chk(16'(ctl.held_rst), 16'h008f);
   endtask

   task automatic t_pll();
      logic [8:0] ua [4];
      ua = '{9'h0fa, 9'h177, 9'h000, 9'h07d};
      host.wr(16'h0020, 8'h1f);
      chk(16'(ctl.fb_ratio), 16'h0042);
      for (int i = 0; i < 4; i++) begin
         host.wr(16'h0022, 8'(i));
         chk(16'(ctl.cp_ua), 16'(ua[i]));
      end
      host.wr(16'h0022, 8'h04);
      chk(16'(ctl.vco_high), 16'h0001);
      host.wr(16'h0022, 8'h08);
      chk(16'({ctl.ref_x2, ctl.vco_high}), 16'h0002);
      @(posedge clk);
      vco_auto_high <= 1'b1;
      host.wr(16'h0022, 8'h80);
      rchk(16'h0022, 8'h84);
   endtask

   task automatic t_soft();
      @(posedge clk);
      straps <= 4'h6;
      host.wr(16'h0404, 8'h11);
      host.wr(16'h0010, 8'h0f);
      host.wr(16'h0000, 8'h3c);
      rchk(16'h0010, 8'h00);
      host.wr(16'h0010, 8'hff);
      host.wr(16'h0000, 8'h18);
      rchk(16'h0010, 8'h00);
      rchk(16'h0404, 8'hc8);
      rchk(16'h0000, 8'h18);
      chk(16'(ctl.mirr[17]), 16'h0000);
      chk(16'(ctl.held_rst), 16'h0000);
      chk(16'(ctl.fb_ratio), 16'h0004);
      chk(16'(latched), 16'h0009);
   endtask

   // a second hard reset latches the straps that stand at that time
   task automatic t_hard();
      host.wr(16'h0010, 8'h04);
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(16'(latched), 16'h0006);
      chk(16'(ctl.refb_pd), 16'h0000);
      rchk(16'h0010, 8'h00);
   endtask

   // with the enable low a write is lost
   task automatic t_ce();
      @(posedge clk);
      ce <= 1'b0;
      host.wr(16'h0020, 8'h05);
      chk(16'(ctl.fb_ratio), 16'h0004);
      @(posedge clk);
      ce <= 1'b1;
      host.wr(16'h0020, 8'h05);
      chk(16'(ctl.fb_ratio), 16'h000e);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         finish_test();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_cfg();
      t_buf();
      t_pwr();
      t_rst();
      t_pll();
      t_soft();
      t_hard();
      t_ce();
      finish_test();
   end
endmodule
